// >>> rtl/irq_bank_cfg.svh
// Offsets, field positions, masks and reset values of the interrupt flag/enable bank
`ifndef IRQ_BANK_CFG_SVH
`define IRQ_BANK_CFG_SVH

// ----------------------------------------------------------------
// Register port geometry
// ----------------------------------------------------------------
`define REG_ADDR_W 3
`define REG_DATA_W 16

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define OFS_FLAG_STATUS_2 3'h0
`define OFS_FLAG_STATUS_6 3'h1
`define OFS_FLAG_STATUS_7 3'h2
`define OFS_ENABLE_0      3'h3
`define OFS_ENABLE_1      3'h4
`define OFS_ENABLE_2      3'h5

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define POS_CIPHER_ROLLOVER    3
`define POS_CIPHER_BUFFER_FREE 2
`define POS_OSC_SELFTUNE       10
`define POS_DEBUG_PORT         5

// ----------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------
`define MASK_FLAG_STATUS_2 16'h000C
`define MASK_FLAG_STATUS_6 16'h0400
`define MASK_FLAG_STATUS_7 16'h0020
`define MASK_ENABLE_0      16'h7FFF
`define MASK_ENABLE_1      16'hFF1F
`define MASK_ENABLE_2      16'h67FF
`define RST_ENABLE         16'h0000
`define RST_FLAGS          4'h0

// ----------------------------------------------------------------
// Index of each held flag inside the flag cell vector
// ----------------------------------------------------------------
`define FLAG_N          4
`define IDX_OSC         0
`define IDX_DBG         1
`define IDX_CROLL       2
`define IDX_CFREE       3

`endif

// >>> rtl/irq_bank_pkg.sv
// Types shared by the interrupt flag/enable bank
`include "irq_bank_cfg.svh"

package irq_bank_pkg;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`REG_ADDR_W-1:0] addr;
    logic [`REG_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } reg_req_type;

  // ----------------------------------------------------------------
  // Set pulses from the sources whose flags live here
  // ----------------------------------------------------------------
  typedef struct packed {
    logic osc_selftune;
    logic debug_port;
    logic cipher_rollover;
    logic cipher_buffer_free;
  } flag_evt_type;

  // Flags of the other flag registers, one word per enable register
  typedef struct packed {
    logic [`REG_DATA_W-1:0] f0;
    logic [`REG_DATA_W-1:0] f1;
    logic [`REG_DATA_W-1:0] f2;
  } src_flags_type;

  // Gated requests toward the CPU interrupt logic
  typedef struct packed {
    logic [`REG_DATA_W-1:0] r0;
    logic [`REG_DATA_W-1:0] r1;
    logic [`REG_DATA_W-1:0] r2;
  } irq_req_type;

  // Held flag levels seen by the outside
  typedef struct packed {
    logic osc_selftune_irq_flag;
    logic debug_port_irq_flag;
    logic cipher_rollover_irq_flag;
    logic cipher_buffer_free_irq_flag;
  } flag_out_type;

  // State of the flag cells
  typedef struct packed {
    logic [`FLAG_N-1:0] flag;
  } flag_state_type;

  // State of the bank
  typedef struct packed {
    logic [`REG_DATA_W-1:0] en0;
    logic [`REG_DATA_W-1:0] en1;
    logic [`REG_DATA_W-1:0] en2;
    logic [`REG_DATA_W-1:0] rdata;
    irq_req_type            req;
  } bank_state_type;

endpackage

// >>> rtl/irq_flag_cells.sv
// Sticky interrupt flag cells, settable by hardware and writable by software
`timescale 1ns/1ps
`include "irq_bank_cfg.svh"

module irq_flag_cells (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Set pulses and software writes
  input  wire logic [`FLAG_N-1:0] set_vec,
  input  wire logic [`FLAG_N-1:0] wr_vec,
  input  wire logic [`FLAG_N-1:0] wr_val,
  // Held flags
  output logic      [`FLAG_N-1:0] flag_q
);
  import irq_bank_pkg::*;

  flag_state_type st_r;
  flag_state_type st_nxt;

  // Per-bit next value; a set in the clearing cycle still lands
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < `FLAG_N; i++) begin
      if (wr_vec[i]) begin
        st_nxt.flag[i] = wr_val[i];
      end
      if (set_vec[i]) begin
        st_nxt.flag[i] = 1'b1;
      end
    end
  end

  // Register the flags, cleared at reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r.flag <= `RST_FLAGS;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_q = st_r.flag;

endmodule

// >>> rtl/irq_flag_enable_bank.sv
// Interrupt flag status 2/6/7 cells and enable registers 0..2 with request gating
//
// What this block does
// [R1] Oscillator self-tune flag lives at bit 10 of flag status 6.
// [R2] Debug port flag lives at bit 5 of flag status 7; rest unimplemented.
// [R3] Unimplemented bits ignore writes and read as zero.
// [R4] Each flag bit is read/write; 1 means its source requested.
// [R5] Each enable bit is read/write; 1 enables, 0 disables the request.
// [R6] All flags and enables clear to zero at reset.
// [R7] Enable 0 bits 14..0 map fifteen sources; bit 15 unimplemented.
// [R8] Enable 1 bits 15..8 and 4..0 implemented; bits 7..5 unimplemented.
// [R9] Enable 2 bits 14, 13, 10..0 implemented; 15, 12, 11 unimplemented.
// [R10] Software routing an external input to a pin is the outside's job.
// [R11] Cipher rollover and buffer-free flags sit at bits 3 and 2 of flag status 2.
// [R12] A request goes forward only while flag and enable are both set.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "irq_bank_cfg.svh"

module irq_flag_enable_bank (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  // Register port
  input  wire irq_bank_pkg::reg_req_type    reg_req,
  output logic      [`REG_DATA_W-1:0]       reg_rdata,
  // Flag sources
  input  wire irq_bank_pkg::flag_evt_type   flag_evt,
  input  wire irq_bank_pkg::src_flags_type  src_flags,
  // Toward the CPU interrupt logic
  output irq_bank_pkg::irq_req_type         irq_req,
  output irq_bank_pkg::flag_out_type        flag_out
);
  import irq_bank_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // One-hot select of the six registers; shared by write and read paths
  function automatic logic [5:0] reg_sel(input logic [`REG_ADDR_W-1:0] a);
    reg_sel = 6'h00;
    case (a)
      `OFS_FLAG_STATUS_2: reg_sel = 6'h01;
      `OFS_FLAG_STATUS_6: reg_sel = 6'h02;
      `OFS_FLAG_STATUS_7: reg_sel = 6'h04;
      `OFS_ENABLE_0:      reg_sel = 6'h08;
      `OFS_ENABLE_1:      reg_sel = 6'h10;
      `OFS_ENABLE_2:      reg_sel = 6'h20;
      default:            reg_sel = 6'h00;
    endcase
  endfunction

  logic [5:0] wsel;
  logic [5:0] rsel;

  // Strobes gate the decode so idle addresses do nothing
  assign wsel = reg_req.wr ? reg_sel(reg_req.addr) : 6'h00;
  assign rsel = reg_req.rd ? reg_sel(reg_req.addr) : 6'h00;

  // ----------------------------------------------------------------
  // Flag cells
  // ----------------------------------------------------------------
  logic [`FLAG_N-1:0] set_vec;
  logic [`FLAG_N-1:0] wr_vec;
  logic [`FLAG_N-1:0] wr_val;
  logic [`FLAG_N-1:0] flag_q;

  // Hardware sets, same clock, so no synchroniser is needed
  always_comb begin
    set_vec               = '0;
    set_vec[`IDX_OSC]     = flag_evt.osc_selftune;       // see [R1]
    set_vec[`IDX_DBG]     = flag_evt.debug_port;         // see [R2]
    set_vec[`IDX_CROLL]   = flag_evt.cipher_rollover;    // see [R11]
    set_vec[`IDX_CFREE]   = flag_evt.cipher_buffer_free; // see [R11]
  end

  // Software writes touch only the implemented flag positions
  always_comb begin
    wr_vec              = '0;
    wr_val              = '0;
    wr_vec[`IDX_OSC]    = wsel[1];                                   // see [R4]
    wr_val[`IDX_OSC]    = reg_req.wdata[`POS_OSC_SELFTUNE];          // see [R1]
    wr_vec[`IDX_DBG]    = wsel[2];                                   // see [R4]
    wr_val[`IDX_DBG]    = reg_req.wdata[`POS_DEBUG_PORT];            // see [R2]
    wr_vec[`IDX_CROLL]  = wsel[0];
    wr_val[`IDX_CROLL]  = reg_req.wdata[`POS_CIPHER_ROLLOVER];       // see [R11]
    wr_vec[`IDX_CFREE]  = wsel[0];
    wr_val[`IDX_CFREE]  = reg_req.wdata[`POS_CIPHER_BUFFER_FREE];    // see [R11]
  end

  irq_flag_cells irq_flag_cells_i (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_vec (set_vec),
    .wr_vec  (wr_vec),
    .wr_val  (wr_val),
    .flag_q  (flag_q)
  );

  // ----------------------------------------------------------------
  // Read views of the flag registers
  // ----------------------------------------------------------------
  logic [`REG_DATA_W-1:0] view_fs2;
  logic [`REG_DATA_W-1:0] view_fs6;
  logic [`REG_DATA_W-1:0] view_fs7;
  logic [`REG_DATA_W-1:0] flags2_merged;

  // Unimplemented positions are tied to zero here, never stored
  always_comb begin
    view_fs2 = '0;
    view_fs6 = '0;
    view_fs7 = '0;
    view_fs2[`POS_CIPHER_ROLLOVER]    = flag_q[`IDX_CROLL];  // see [R11]
    view_fs2[`POS_CIPHER_BUFFER_FREE] = flag_q[`IDX_CFREE];  // see [R11]
    view_fs6[`POS_OSC_SELFTUNE]       = flag_q[`IDX_OSC];    // see [R1] [R3]
    view_fs7[`POS_DEBUG_PORT]         = flag_q[`IDX_DBG];    // see [R2] [R3]
  end

  // Cipher flags held here replace the outside copy at bits 3..2
  always_comb begin
    flags2_merged = src_flags.f2 & ~`MASK_FLAG_STATUS_2;
    flags2_merged = flags2_merged | view_fs2;
  end

  // ----------------------------------------------------------------
  // Bank state: enables, read data, gated requests
  // ----------------------------------------------------------------
  bank_state_type st_r;
  bank_state_type st_nxt;

  // Next-state: masked writes, registered read data, request gating
  always_comb begin
    st_nxt = st_r;
    if (wsel[3]) begin
      st_nxt.en0 = reg_req.wdata & `MASK_ENABLE_0;  // see [R5] [R7] [R3]
    end
    if (wsel[4]) begin
      st_nxt.en1 = reg_req.wdata & `MASK_ENABLE_1;  // see [R5] [R8] [R3]
    end
    if (wsel[5]) begin
      st_nxt.en2 = reg_req.wdata & `MASK_ENABLE_2;  // see [R5] [R9] [R3]
    end
    // Unmapped or idle reads return zero
    st_nxt.rdata = '0;
    unique case (1'b1)
      rsel[0]: st_nxt.rdata = view_fs2;
      rsel[1]: st_nxt.rdata = view_fs6;
      rsel[2]: st_nxt.rdata = view_fs7;
      rsel[3]: st_nxt.rdata = st_r.en0;
      rsel[4]: st_nxt.rdata = st_r.en1;
      rsel[5]: st_nxt.rdata = st_r.en2;
      default: st_nxt.rdata = '0;
    endcase
    // Disabled sources still latch their flag; only the request is held back
    st_nxt.req.r0 = src_flags.f0 & st_r.en0;     // see [R12]
    st_nxt.req.r1 = src_flags.f1 & st_r.en1;     // see [R12]
    st_nxt.req.r2 = flags2_merged & st_r.en2;    // see [R12]
  end

  // Single state register, cleared by the synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r.en0   <= `RST_ENABLE;  // see [R6]
      st_r.en1   <= `RST_ENABLE;
      st_r.en2   <= `RST_ENABLE;
      st_r.rdata <= '0;
      st_r.req   <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // External-input enables only matter once the pin mux routes a pin (R10 outside)
  assign reg_rdata = st_r.rdata;
  assign irq_req   = st_r.req;
  assign flag_out.osc_selftune_irq_flag       = flag_q[`IDX_OSC];
  assign flag_out.debug_port_irq_flag         = flag_q[`IDX_DBG];
  assign flag_out.cipher_rollover_irq_flag    = flag_q[`IDX_CROLL];
  assign flag_out.cipher_buffer_free_irq_flag = flag_q[`IDX_CFREE];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_selftune_set;
    @(posedge sys_clk) disable iff (!nrst)
    flag_evt.osc_selftune |=> flag_out.osc_selftune_irq_flag;
  endproperty
  a_selftune_set: assert property (p_selftune_set) // see [R1]
    else $error("self-tune event did not set its flag");

  property p_fs7_read;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.rd && reg_req.addr == `OFS_FLAG_STATUS_7) |=>
      reg_rdata == ($past(flag_out.debug_port_irq_flag) ? `MASK_FLAG_STATUS_7 : 16'h0000);
  endproperty
  a_fs7_read: assert property (p_fs7_read) // see [R2]
    else $error("flag status 7 read shows wrong value");

  property p_fs6_read;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.rd && reg_req.addr == `OFS_FLAG_STATUS_6) |=>
      (reg_rdata & ~`MASK_FLAG_STATUS_6) == 16'h0000
      && reg_rdata[`POS_OSC_SELFTUNE] == $past(flag_out.osc_selftune_irq_flag);
  endproperty
  a_fs6_read: assert property (p_fs6_read) // see [R3]
    else $error("flag status 6 read shows unimplemented bits or wrong flag");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == `OFS_FLAG_STATUS_6
      && !reg_req.wdata[`POS_OSC_SELFTUNE] && !flag_evt.osc_selftune)
      |=> !flag_out.osc_selftune_irq_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // see [R4]
    else $error("software clear of self-tune flag ignored");

  property p_en0_write;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == `OFS_ENABLE_0) ##1
      (reg_req.rd && reg_req.addr == `OFS_ENABLE_0)
      |=> reg_rdata == ($past(reg_req.wdata, 2) & `MASK_ENABLE_0);
  endproperty
  a_en0_write: assert property (p_en0_write) // see [R7]
    else $error("enable 0 readback differs from masked write");

  property p_en1_write;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == `OFS_ENABLE_1)
      |=> st_r.en1 == ($past(reg_req.wdata) & `MASK_ENABLE_1);
  endproperty
  a_en1_write: assert property (p_en1_write) // see [R8]
    else $error("enable 1 did not take masked write");

  property p_en2_write;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == `OFS_ENABLE_2)
      |=> st_r.en2 == ($past(reg_req.wdata) & `MASK_ENABLE_2);
  endproperty
  a_en2_write: assert property (p_en2_write) // see [R9] [R5]
    else $error("enable 2 did not take masked write");

  property p_reset_clear;
    @(posedge sys_clk)
    !nrst |=> (st_r.en0 == 16'h0000 && st_r.en1 == 16'h0000
      && st_r.en2 == 16'h0000 && flag_q == 4'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // see [R6]
    else $error("bank not cleared by reset");

  property p_cipher_set;
    @(posedge sys_clk) disable iff (!nrst)
    (flag_evt.cipher_rollover && flag_evt.cipher_buffer_free) ##1
      (reg_req.rd && reg_req.addr == `OFS_FLAG_STATUS_2) |=> reg_rdata == `MASK_FLAG_STATUS_2;
  endproperty
  a_cipher_set: assert property (p_cipher_set) // see [R11]
    else $error("cipher flags not seen at bits 3 and 2");

  property p_req_gate;
    @(posedge sys_clk) disable iff (!nrst)
    ##1 (irq_req.r0 == ($past(src_flags.f0) & $past(st_r.en0))
      && irq_req.r1 == ($past(src_flags.f1) & $past(st_r.en1)));
  endproperty
  a_req_gate: assert property (p_req_gate) // see [R12]
    else $error("request not equal to flag and enable");

  property p_debug_set;
    @(posedge sys_clk) disable iff (!nrst)
    flag_evt.debug_port |=> flag_out.debug_port_irq_flag;
  endproperty
  a_debug_set: assert property (p_debug_set) // see [R2]
    else $error("debug port event did not set its flag");

  property p_debug_clear;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == `OFS_FLAG_STATUS_7
      && !reg_req.wdata[`POS_DEBUG_PORT] && !flag_evt.debug_port)
      |=> !flag_out.debug_port_irq_flag;
  endproperty
  a_debug_clear: assert property (p_debug_clear) // see [R4]
    else $error("software clear of debug port flag ignored");

  // A held flag only drops through a software write of its own word
  property p_cipher_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (flag_out.cipher_rollover_irq_flag
      && !(reg_req.wr && reg_req.addr == `OFS_FLAG_STATUS_2))
      |=> flag_out.cipher_rollover_irq_flag;
  endproperty
  a_cipher_hold: assert property (p_cipher_hold) // see [R4]
    else $error("cipher rollover flag dropped without a write");

  property p_unmapped_read;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_req.rd && reg_req.addr > `OFS_ENABLE_2) |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // see [R3]
    else $error("unmapped word read back nonzero");

  // Bits 3..2 of the third request word come from the flags held here
  property p_req_gate_cipher;
    @(posedge sys_clk) disable iff (!nrst)
    ##1 (irq_req.r2 == ((($past(src_flags.f2) & 16'hFFF3)
      | {12'h000, $past(flag_out.cipher_rollover_irq_flag),
         $past(flag_out.cipher_buffer_free_irq_flag), 2'b00}) & $past(st_r.en2)));
  endproperty
  a_req_gate_cipher: assert property (p_req_gate_cipher) // see [R12] [R11]
    else $error("third request word not equal to flag and enable");

endmodule

// >>> verif/irq_source_model.sv
// Behavioural model of the peripheral request sources feeding the bank
`timescale 1ns/1ps

module irq_source_model (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // Commands from the bench
  input  wire irq_bank_pkg::flag_evt_type  evt_cmd,
  input  wire irq_bank_pkg::src_flags_type src_cmd,
  // Toward the bank
  output irq_bank_pkg::flag_evt_type       flag_evt,
  output irq_bank_pkg::src_flags_type      src_flags
);
  import irq_bank_pkg::*;

  // Sources move just after the edge, one cycle behind the command
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flag_evt  <= '0;
      src_flags <= '0;
    end else begin
      flag_evt  <= evt_cmd;
      // External inputs arrive here already routed to a pin
      src_flags <= src_cmd;
    end
  end
endmodule

// >>> verif/interrupt_flag_enable_bank_bench.sv
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
`include "irq_bank_cfg.svh"

module interrupt_flag_enable_bank_bench;
  import irq_bank_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic          sys_clk;
  logic          nrst;
  reg_req_type   req;
  logic [15:0]   reg_rdata;
  flag_evt_type  flag_evt;
  flag_evt_type  evt_cmd;
  src_flags_type src_flags;
  src_flags_type src_cmd;
  irq_req_type   irq_req;
  flag_out_type  flag_out;
  int            bad_count;
  int            check_count;
  int            cycles;
  integer        seed;
  logic [15:0]   en_m [3];
  logic [15:0]   cf;
  logic [15:0]   d;
  logic [2:0]    a;
  // Register and bit that each event lands in, osc first
  logic [2:0]    ev_a [4] = '{`OFS_FLAG_STATUS_6, `OFS_FLAG_STATUS_7,
                              `OFS_FLAG_STATUS_2, `OFS_FLAG_STATUS_2};
  logic [15:0]   ev_v [4] = '{16'h0400, 16'h0020, 16'h0008, 16'h0004};

  irq_flag_enable_bank irq_flag_enable_bank_i (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .reg_req   (req),
    .reg_rdata (reg_rdata),
    .flag_evt  (flag_evt),
    .src_flags (src_flags),
    .irq_req   (irq_req),
    .flag_out  (flag_out)
  );

  irq_source_model irq_source_model_i (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .evt_cmd   (evt_cmd),
    .src_cmd   (src_cmd),
    .flag_evt  (flag_evt),
    .src_flags (src_flags)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Implemented bits per word index; unmapped words have none
  function automatic logic [15:0] impl_mask(input logic [2:0] ad);
    case (ad)
      `OFS_FLAG_STATUS_2: return `MASK_FLAG_STATUS_2;
      `OFS_FLAG_STATUS_6: return `MASK_FLAG_STATUS_6;
      `OFS_FLAG_STATUS_7: return `MASK_FLAG_STATUS_7;
      `OFS_ENABLE_0:      return `MASK_ENABLE_0;
      `OFS_ENABLE_1:      return `MASK_ENABLE_1;
      `OFS_ENABLE_2:      return `MASK_ENABLE_2;
      default:            return 16'h0000;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [2:0] ad, input logic [15:0] wd);
    @(posedge sys_clk);
    req.addr  <= ad;
    req.wdata <= wd;
    req.wr    <= 1'b1;
    @(posedge sys_clk);
    req.wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] ad, input logic [15:0] exp);
    @(posedge sys_clk);
    req.addr <= ad;
    req.rd   <= 1'b1;
    @(posedge sys_clk);
    req.rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // Write then read the same word with no gap between the strobes
  task automatic wr_rd_chk(input logic [2:0]  ad,
                           input logic [15:0] wd,
                           input logic [15:0] exp);
    @(posedge sys_clk);
    req.addr  <= ad;
    req.wdata <= wd;
    req.wr    <= 1'b1;
    @(posedge sys_clk);
    req.wr    <= 1'b0;
    req.rd    <= 1'b1;
    @(posedge sys_clk);
    req.rd    <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Whole run needs under five hundred cycles; this leaves ample room
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    req = '0;
    evt_cmd = '0;
    src_cmd = '0;
    seed = 32'hbc3e16e5;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, unmapped words included
    for (int i = 0; i < 8; i++) rd_chk(3'(i), 16'h0000);
    @(posedge sys_clk);
    #1;
    check(reg_rdata, 16'h0000);
    $display("test reset_values done");
    // Enable and unmapped words: all ones, zeros; then random values on enable words
    for (int i = 3; i < 8; i++) begin
      reg_write(3'(i), 16'hFFFF);
      rd_chk(3'(i), impl_mask(3'(i)));
      reg_write(3'(i), 16'h0000);
      rd_chk(3'(i), 16'h0000);
    end
    for (int n = 0; n < 24; n++) begin
      a = 3'(3 + ($unsigned($random(seed)) % 3));
      d = 16'($random(seed));
      wr_rd_chk(a, d, d & impl_mask(a));
    end
    $display("test enable_words done");
    // Software set and clear of every held flag
    for (int i = 0; i < 3; i++) reg_write(3'(i), 16'hFFFF);
    #1;
    check({12'h000, flag_out}, 16'h000F);
    for (int i = 0; i < 3; i++) begin
      rd_chk(3'(i), impl_mask(3'(i)));
      reg_write(3'(i), 16'h0000);
      rd_chk(3'(i), 16'h0000);
    end
    $display("test flag_writes done");
    // Hardware set of each flag; a clear during a held event loses
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      evt_cmd <= flag_evt_type'(4'h8 >> k);
      repeat (3) @(posedge sys_clk);
      #1;
      check({12'h000, flag_out}, 16'(4'h8 >> k));
      reg_write(ev_a[k], 16'h0000);
      rd_chk(ev_a[k], ev_v[k]);
      @(posedge sys_clk);
      evt_cmd <= '0;
      repeat (2) @(posedge sys_clk);
      reg_write(ev_a[k], 16'h0000);
      rd_chk(ev_a[k], 16'h0000);
    end
    // Both cipher events held together while the word is read
    @(posedge sys_clk);
    evt_cmd <= flag_evt_type'(4'h3);
    repeat (3) @(posedge sys_clk);
    rd_chk(`OFS_FLAG_STATUS_2, `MASK_FLAG_STATUS_2);
    @(posedge sys_clk);
    evt_cmd <= '0;
    $display("test flag_events done");
    // Gated requests with random flags and enables
    for (int n = 0; n < 16; n++) begin
      for (int i = 0; i < 3; i++) begin
        d = 16'($random(seed));
        reg_write(3'(3 + i), d);
        en_m[i] = d & impl_mask(3'(3 + i));
      end
      d = 16'($random(seed));
      reg_write(`OFS_FLAG_STATUS_2, d);
      cf = d & `MASK_FLAG_STATUS_2;
      @(posedge sys_clk);
      src_cmd <= {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
      repeat (3) @(posedge sys_clk);
      #1;
      check(irq_req.r0, src_cmd.f0 & en_m[0]);
      check(irq_req.r1, src_cmd.f1 & en_m[1]);
      check(irq_req.r2, ((src_cmd.f2 & ~16'h000C) | cf) & en_m[2]);
    end
    $display("test request_gating done");
    // Second reset in mid-run with state loaded
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check(irq_req.r0 | irq_req.r1 | irq_req.r2, 16'h0000);
    for (int i = 0; i < 6; i++) rd_chk(3'(i), 16'h0000);
    $display("test mid_reset done");
    complete_run();
  end
endmodule
